// ==== core/blbsd_pkg.sv ====
// Package with constants for the byte lane bus sizing block.
package blbsd_pkg;
    // ---------------------------------------------
    // Widths and lane codes
    // ---------------------------------------------
    localparam int LANES = 4;
    localparam logic [3:0] LANES_NONE = 4'hf;   // Active low: all negated
    localparam logic [3:0] LANES_ALL  = 4'h0;
    localparam logic [4:0] LINE_BYTES = 5'h10;  // Cache line length in bytes
    localparam logic [4:0] HALF_STEP  = 5'h02;
    localparam logic [4:0] BYTE_STEP  = 5'h01;
    localparam logic [4:0] WORD_STEP  = 5'h04;
    localparam logic [4:0] MAX_FILL_CYCLES = 5'h10;
    localparam logic [1:0] SIZE_FULL  = 2'h0;
    localparam logic [1:0] SIZE_HALF  = 2'h1;
    localparam logic [1:0] SIZE_BYTE  = 2'h2;
    typedef enum logic [1:0] {BLBSD_IDLE, BLBSD_XFER, BLBSD_FILL} blbsd_state_e;
endpackage

// ==== core/blbsd_lane_order.sv ====
// Next byte lane pattern after a part-width acknowledge.
`timescale 1ns/100ps
module blbsd_lane_order
    import blbsd_pkg::*;
(
    input  wire logic [3:0] laneNow,    // Current active-low lane enables
    input  wire logic       halfAck,    // Half-width acknowledge, active high
    input  wire logic       byteAck,    // Byte-width acknowledge, active high
    input  wire logic [3:0] laneMask,   // Bytes still owed, active high
    output logic      [3:0] laneNext,   // Remaining lanes, active low
    output logic            laneDone    // Nothing left
);
    // ---------------------------------------------
    // Lowest owed byte or halfword goes first
    // ---------------------------------------------
    // The present cycle carries only its lowest part; the owed mask keeps the rest
    wire  [3:0] doneNow     = ~laneNow;
    wire  [3:0] lowOne      = doneNow & (~doneNow + 4'h1);
    wire        lowHalfPart = |(doneNow & 4'h3);
    wire  [3:0] halfPart    = lowHalfPart ? (doneNow & 4'h3) : (doneNow & 4'hc);
    wire  [3:0] curSent     = byteAck ? lowOne : halfAck ? halfPart : doneNow;
    wire  [3:0] left        = laneMask & ~curSent;
    assign laneDone = (left == 4'h0);
    assign laneNext = laneDone ? LANES_NONE : ~left;
endmodule

// ==== core/blbsd_top.sv ====
// Processor side bus sizing sequencer driving contiguous byte lane enables.
`timescale 1ns/100ps
module blbsd_top
    import blbsd_pkg::*;
(
    input  wire logic        clock,         // 25 MHz bus clock
    input  wire logic        reset,         // Synchronous, active high
    input  wire logic        reqValid,      // Operand request pulse
    input  wire logic [31:0] reqAddr,       // Operand byte address
    input  wire logic [2:0]  reqLen,        // Operand length 1, 2 or 4
    input  wire logic        reqFill,       // Request is a cache line fill
    input  wire logic        cycleDone,     // Ready for the current cycle
    input  wire logic        halfwidth_port_ack, // Half-width acknowledge, high
    input  wire logic        bytewidth_port_ack, // Byte-width acknowledge, high
    output logic      [3:0]  byte_lane_enables_n, // Active-low lane enables
    output logic      [29:0] wordAddr,      // Physical word address
    output logic             busActive,     // A cycle is on the bus
    output logic             fillFirst,     // First cycle of a line fill
    output logic             reqBusy        // Operand in progress
);
    import blbsd_pkg::*;
    // ---------------------------------------------
    // State
    // ---------------------------------------------
    blbsd_state_e state;
    logic [3:0]  owedHigh;   // Bytes owed in the lower word after the high word, active high
    logic [4:0]  fillCount;
    logic [29:0] baseWord;
    logic        onHigh;
    // ---------------------------------------------
    // Operand decode
    // ---------------------------------------------
    wire  [1:0] offset = reqAddr[1:0];
    wire  [3:0] lenMask = (reqLen == 3'h4) ? 4'hf : (reqLen == 3'h2) ? 4'h3 : 4'h1;
    wire  [7:0] spanMask = {4'h0, lenMask} << offset;
    wire        crosses = |spanMask[7:4];
    wire  [3:0] lowPart = spanMask[3:0];
    wire  [3:0] highPart = spanMask[7:4];
    wire        narrow = halfwidth_port_ack | bytewidth_port_ack;
    // ---------------------------------------------
    // Narrow split within one physical word
    // ---------------------------------------------
    wire  [3:0] laneNext;
    wire        laneDone;
    blbsd_lane_order order (
        .laneNow  (byte_lane_enables_n),
        .halfAck  (halfwidth_port_ack),
        .byteAck  (bytewidth_port_ack),
        .laneMask (~byte_lane_enables_n),
        .laneNext (laneNext),
        .laneDone (laneDone)
    );
    wire        splitMore = narrow && !laneDone;
    // ---------------------------------------------
    // Line fill walk
    // ---------------------------------------------
    // A byte count, not a cycle count, moves the fill on, so one adder serves
    // all three port widths. Every later cycle enables the bytes still owed in
    // its word: a narrow port takes the lowest of them, which is the same
    // pattern that a plain split of that word would show.
    wire  [4:0] fillStep = bytewidth_port_ack ? BYTE_STEP
                         : halfwidth_port_ack ? HALF_STEP : WORD_STEP;
    wire  [4:0] fillNextCount = fillCount + fillStep;
    wire        fillOver = fillNextCount >= LINE_BYTES;
    wire  [1:0] fillLane = fillNextCount[1:0];
    wire  [3:0] fillLanes = bytewidth_port_ack ? ~(4'hf << fillLane)
                          : halfwidth_port_ack ? (fillLane[1] ? 4'h3 : LANES_ALL)
                          : LANES_ALL;
    // ---------------------------------------------
    // Sequencer
    // ---------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            state <= BLBSD_IDLE;
            byte_lane_enables_n <= LANES_NONE;
            wordAddr <= 30'h0;
            baseWord <= 30'h0;
            owedHigh <= 4'h0;
            fillCount <= 5'h0;
            onHigh <= 1'b0;
            busActive <= 1'b0;
            fillFirst <= 1'b0;
            reqBusy <= 1'b0;
        end else begin
            case (state)
                BLBSD_IDLE: begin
                    if (reqValid) begin
                        busActive <= 1'b1;
                        reqBusy <= 1'b1;
                        baseWord <= reqAddr[31:2];
                        if (reqFill) begin
                            // A fill opens on the first word of its line with
                            // every lane on; the port may answer at any width
                            state <= BLBSD_FILL;
                            fillCount <= 5'h0;
                            fillFirst <= 1'b1;
                            wordAddr <= {reqAddr[31:4], 2'h0};
                            byte_lane_enables_n <= LANES_ALL;
                        end else if (crosses) begin
                            // High word goes first, whatever the port width
                            state <= BLBSD_XFER;
                            onHigh <= 1'b1;
                            owedHigh <= lowPart;
                            wordAddr <= reqAddr[31:2] + 30'h1;
                            byte_lane_enables_n <= ~highPart;
                        end else begin
                            state <= BLBSD_XFER;
                            onHigh <= 1'b0;
                            owedHigh <= 4'h0;
                            wordAddr <= reqAddr[31:2];
                            byte_lane_enables_n <= ~lowPart;
                        end
                    end
                end
                BLBSD_XFER: begin
                    if (cycleDone) begin
                        // A narrow answer finishes this word before the other one
                        if (splitMore) begin
                            byte_lane_enables_n <= laneNext;
                        end else if (onHigh) begin
                            onHigh <= 1'b0;
                            wordAddr <= baseWord;
                            byte_lane_enables_n <= ~owedHigh;
                        end else begin
                            state <= BLBSD_IDLE;
                            busActive <= 1'b0;
                            reqBusy <= 1'b0;
                            byte_lane_enables_n <= LANES_NONE;
                        end
                    end
                end
                BLBSD_FILL: begin
                    if (cycleDone) begin
                        // Only the first answer of a fill is marked, whatever its width
                        fillFirst <= 1'b0;
                        if (fillOver) begin
                            state <= BLBSD_IDLE;
                            busActive <= 1'b0;
                            reqBusy <= 1'b0;
                            byte_lane_enables_n <= LANES_NONE;
                        end else begin
                            fillCount <= fillNextCount;
                            wordAddr <= {wordAddr[29:2], fillNextCount[3:2]};
                            byte_lane_enables_n <= fillLanes;
                        end
                    end
                end
                default: state <= BLBSD_IDLE;
            endcase
        end
    end
    // ---------------------------------------------
    // Checks
    // ---------------------------------------------
    // Adding the lowest active lane to a contiguous run clears the run;
    // a gap leaves a stray bit behind. The carry out of lane 3 is meant to drop.
    wire  [3:0] actLanes   = ~byte_lane_enables_n;
    wire  [3:0] lowestLane = actLanes & (~actLanes + 4'h1);
    wire  [3:0] runCleared = actLanes + lowestLane;
    wire        contiguous = (runCleared & actLanes) == 4'h0;
    lanes_contig_a: assert property (@(posedge clock) disable iff (reset)
        busActive |-> contiguous)
        else $error("gapped lane enables");
    fill_bound_a: assert property (@(posedge clock) disable iff (reset)
        state == BLBSD_FILL |-> fillCount < MAX_FILL_CYCLES)
        else $error("fill too long");
    // A crossing operand opens on the word above the one it starts in
    cross_order_a: assert property (@(posedge clock) disable iff (reset)
        (state == BLBSD_IDLE && reqValid && !reqFill && crosses) |=> onHigh)
        else $error("high word not first");
    idle_lanes_a: assert property (@(posedge clock) disable iff (reset)
        !busActive |-> byte_lane_enables_n == LANES_NONE)
        else $error("lanes enabled with no cycle on the bus");
    // A split cycle may only drop lanes, and the lowest one goes first
    split_low_first_a: assert property (@(posedge clock) disable iff (reset)
        (state == BLBSD_XFER && cycleDone && splitMore) |=>
        ((actLanes & ~$past(actLanes)) == 4'h0) && ((actLanes & $past(lowestLane)) == 4'h0))
        else $error("narrow split did not move the lowest part first");
    // After a half split only the upper half can still be owed
    half_split_a: assert property (@(posedge clock) disable iff (reset)
        (state == BLBSD_XFER && cycleDone && halfwidth_port_ack && splitMore) |=>
        byte_lane_enables_n[1:0] == 2'h3)
        else $error("half split left a low lane enabled");
    byte_split_a: assert property (@(posedge clock) disable iff (reset)
        (state == BLBSD_XFER && cycleDone && bytewidth_port_ack && splitMore) |=>
        actLanes == ($past(actLanes) & ~$past(lowestLane)))
        else $error("byte split did not drop exactly one lane");
    // The last answer of an operand returns the bus to idle at once
    xfer_end_a: assert property (@(posedge clock) disable iff (reset)
        (state == BLBSD_XFER && cycleDone && !splitMore && !onHigh) |=>
        !reqBusy && !busActive && byte_lane_enables_n == LANES_NONE)
        else $error("operand did not end after its last cycle");
    fill_start_a: assert property (@(posedge clock) disable iff (reset)
        fillFirst |-> byte_lane_enables_n == LANES_ALL && wordAddr[1:0] == 2'h0)
        else $error("line fill did not open on the first word");
    // The whole fill stays inside one line
    fill_line_a: assert property (@(posedge clock) disable iff (reset)
        state == BLBSD_FILL |-> wordAddr[29:2] == baseWord[29:2])
        else $error("line fill left its line");
    fill_end_a: assert property (@(posedge clock) disable iff (reset)
        (state == BLBSD_FILL && cycleDone && fillOver) |=> !reqBusy && !fillFirst)
        else $error("line fill ran past its last byte");
endmodule

// ==== testbench/blbsd_narrow_port.sv ====
// Narrow memory model: answers bus cycles and decodes 16-bit lane selects.
`timescale 1ns/100ps
module blbsd_narrow_port
    import blbsd_pkg::*;
(
    input  wire logic       clock,      // Bus clock
    input  wire logic       reset,      // Synchronous, active high
    input  wire logic [1:0] portSize,   // SIZE_FULL, SIZE_HALF or SIZE_BYTE
    input  wire logic [1:0] waitCycles, // Wait states before each ready
    input  wire logic [3:0] laneEnN,    // Lane enables, active low
    input  wire logic       busActive,  // Cycle on the bus
    input  wire logic       fillFirst,  // First line fill cycle
    output logic            cycleDone,  // Ready for the current cycle
    output logic            halfAck,    // Half-width acknowledge
    output logic            byteAck,    // Byte-width acknowledge
    output logic            lowerSelN,  // Lower lane select, active low
    output logic            upperSelN,  // Upper lane select, active low
    output logic            halfSel,    // Halfword select bit
    output logic            byteSel     // Byte select bit
);
    // ---------------------------------------------
    // Select decode and cycle answer
    // ---------------------------------------------
    logic [1:0] waitCount;
    wire  [3:0] act = fillFirst ? 4'hf : ~laneEnN;
    // Gapped or idle patterns fall where they may: no state, no
    assign halfSel   = (act[1:0] == 2'h0);
    assign lowerSelN = halfSel ? ~act[2] : ~act[0];
    assign upperSelN = fillFirst ? 1'b0 : (halfSel ? ~act[3] : ~act[1]);
    assign byteSel   = lowerSelN;
    // Width answer held as a level, also during fills
    assign halfAck   = (portSize == SIZE_HALF);
    assign byteAck   = (portSize == SIZE_BYTE);
    always_ff @(posedge clock) begin
        if (reset || cycleDone || !busActive) begin
            cycleDone <= 1'b0;
            waitCount <= 2'h0;
        end else if (waitCount == waitCycles) begin
            cycleDone <= 1'b1;
        end else begin
            waitCount <= waitCount + 2'h1;
        end
    end
endmodule

// ==== testbench/test_byte_lane_bus_sizing_decoder.sv ====
// Self-checking bench for the bus sizing sequencer.
`timescale 1ns/100ps
`define CHECK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin nErrors++; \
    $display("wrong value %s expected %0h seen %0h", what, exp, got); end end
module test_byte_lane_bus_sizing_decoder;
    import blbsd_pkg::*;
    logic clock, reset, reqValid, reqFill, cycleDone, halfAck, byteAck;
    logic busActive, fillFirst, reqBusy, lowerSelN, upperSelN, halfSel, byteSel;
    logic [31:0] reqAddr;
    logic [2:0]  reqLen;
    logic [1:0]  portSize, waitCycles;
    logic [3:0]  laneEnN;
    logic [29:0] wordAddr;
    logic [34:0] expQ[$];
    int nErrors, comparisons;
    // ---------------------------------------------
    // Expected cycle list
    // ---------------------------------------------
    function automatic logic [3:0] shrink(input logic [3:0] m, input logic [1:0] s);
        if (s == SIZE_BYTE) return m & (m - 4'h1);
        if (s == SIZE_HALF && m[1:0] != 2'h0) return {m[3:2], 2'h0};
        return 4'h0;
    endfunction
    task automatic piece(input logic [29:0] w, input logic [3:0] m, input logic first,
                         input logic [1:0] s);
        while (m != 4'h0) begin
            expQ.push_back({first, w, ~m});
            first = 1'b0;
            m = shrink(m, s);
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d errors %0d", comparisons, nErrors);
        if (nErrors == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic run(input logic [31:0] a, input logic [2:0] len, input logic fill,
                       input logic [1:0] s, input logic poke);
        logic [7:0] span;
        int n;
        // Drive on an edge, never in the step in which the last loop looked
        @(posedge clock);
        span = ((8'h01 << len) - 8'h01) << a[1:0];
        portSize <= s;
        waitCycles <= 2'($urandom_range(2));
        reqAddr <= a;
        reqLen <= len;
        reqFill <= fill;
        reqValid <= 1'b1;
        if (fill) for (int i = 0; i < 4; i++) piece(a[31:2] + 30'(i), 4'hf, i == 0, s);
        else begin
            if (span[7:4] != 4'h0) piece(a[31:2] + 30'h1, span[7:4], 1'b0, s);
            piece(a[31:2], span[3:0], 1'b0, s);
        end
        n = 0;
        do begin
            @(posedge clock);
            reqValid <= poke && n == 1;  // Lands while busy, so it must be refused
            #1 n++;
        end while (reqBusy !== 1'b0 && n < 500);
        if (n >= 500) begin
            nErrors++;
            end_sim();
        end
        `CHECK("idle lanes", 4'hf, laneEnN)
        `CHECK("bus idle", 1'b0, busActive)
        `CHECK("cycles left", 32'h0, 32'(expQ.size()))
        expQ.delete();
    endtask
    // ---------------------------------------------
    // Cycle monitor and stimulus
    // ---------------------------------------------
    always @(posedge clock) if (!reset && busActive && cycleDone) begin
        logic [34:0] e;
        e = (expQ.size() != 0) ? expQ.pop_front() : {35{1'b1}};
        `CHECK("lanes", e[3:0], laneEnN)
        `CHECK("word", e[33:4], wordAddr)
        `CHECK("fill first", e[34], fillFirst)
        if (e[34]) `CHECK("fill selects", 4'h0, {halfSel, upperSelN, byteSel, lowerSelN})
    end
    always #20 clock = ~clock;
    initial begin
        clock = 0; reset = 1; reqValid = 0; reqAddr = 0; reqLen = 3'h1; reqFill = 0;
        portSize = SIZE_FULL; waitCycles = 0; nErrors = 0; comparisons = 0;
        void'($urandom(32'h26a8467e));
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        for (int s = 0; s < 3; s++) begin
            run(32'h2000, 3'h4, 1'b1, 2'(s), 1'b1);
            for (int o = 0; o < 4; o++) for (int l = 1; l <= 4; l = l * 2)
                run(32'h1000 + o, 3'(l), 1'b0, 2'(s), 1'b0);
        end
        repeat (80) begin
            logic f;
            logic [31:0] a;
            f = ($urandom_range(3) == 0);
            a = $urandom;
            if (f) a[3:0] = 4'h0;
            run(a, f ? 3'h4 : 3'(1 << $urandom_range(2)), f, 2'($urandom_range(2)),
                1'($urandom));
        end
        end_sim();
    end
    blbsd_top blbsd_top_inst (.clock(clock), .reset(reset), .reqValid(reqValid),
        .reqAddr(reqAddr), .reqLen(reqLen), .reqFill(reqFill), .cycleDone(cycleDone),
        .halfwidth_port_ack(halfAck), .bytewidth_port_ack(byteAck),
        .byte_lane_enables_n(laneEnN), .wordAddr(wordAddr), .busActive(busActive),
        .fillFirst(fillFirst), .reqBusy(reqBusy));
    blbsd_narrow_port blbsd_narrow_port_inst (.clock(clock), .reset(reset),
        .portSize(portSize), .waitCycles(waitCycles), .laneEnN(laneEnN),
        .busActive(busActive), .fillFirst(fillFirst), .cycleDone(cycleDone),
        .halfAck(halfAck), .byteAck(byteAck), .lowerSelN(lowerSelN),
        .upperSelN(upperSelN), .halfSel(halfSel), .byteSel(byteSel));
endmodule
